// ### bench/pmws_core_model.sv
/*
  pmws_core_model: stand-in for the core and its interrupt controller.
  assumes the bench pulses sleep_go for one cycle and holds go_mask.
*/
`timescale 1ns/1ns
// ==========================================================
// core side model
module pmws_core_model (
  input  wire logic        hclk,
  input  wire logic        sleep_go,  // bench asks for entry
  input  wire logic        slow,      // answer one cycle late
  input  wire logic [31:0] go_mask,   // enabled, urgent irqs
  output logic             sleep_req,
  output logic [31:0]      irq_mask
);
  logic        go_d  = 1'b0;         // delayed request
  logic [31:0] noise = 32'hC3A51E69; // junk shown outside entry
  // the mask churns outside entry so a late capture is caught
  always @(posedge hclk) begin
    go_d <= sleep_go;
    noise <= {noise[30:0], noise[31] ^ noise[27]};
  end
  assign sleep_req = slow ? go_d : sleep_go;
  assign irq_mask  = sleep_req ? go_mask : noise;
endmodule

// ### bench/tb_top.sv
/*
  tb_top: self-checking bench for pmws_seq.
  assumes the package and the core model are compiled first.
*/
`timescale 1ns/1ns
// ==========================================================
// bench top
module tb_top
  import pmws_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        ext_reset_n, osc_stable, rtc_alarm, sleep_go, slow;
  logic        sleep_req, sys_reset_n, usb_pll_en, usb_clk_sel;
  logic        main_pll_en, main_pll_con, wake_event;
  logic [31:0] haddr, hwdata, hrdata, irq_lines, irq_mask, go_mask;
  logic [31:0] periph_clk_en, rd, m;
  logic [1:0]  htrans, clk_src;
  logic [2:0]  hsize;
  logic [7:0]  cpu_div;
  logic [3:0]  usb_div;
  pmws_pwr_t   pwr;
  int          fails, samples_checked, n, b;
  pmws_seq pmws_seq_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .ext_reset_n, .osc_stable, .sleep_req, .irq_mask, .irq_lines, .rtc_alarm,
    .sys_reset_n, .pwr, .usb_pll_en, .usb_clk_sel, .main_pll_en,
    .main_pll_con, .clk_src, .cpu_div, .usb_div, .periph_clk_en, .wake_event);
  pmws_core_model pmws_core_model_inst (.hclk, .sleep_go, .slow, .go_mask,
    .sleep_req, .irq_mask);
  // ==========================================================
  // clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ==========================================================
  // reporting
  task automatic conclude();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    samples_checked++;
    if (g < lo || g > hi) begin
      fails++;
      $display("FAIL %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask
  // ==========================================================
  // bounded waits: 0 reset release, 1 wake pulse, 2 flash ready
  function automatic logic probe(input int k);
    case (k)
      0: return sys_reset_n;
      1: return wake_event;
      default: return pwr.flash_ok;
    endcase
  endfunction
  task automatic wait_for(input int k, input int lim);
    n = 0;
    while (probe(k) !== 1'b1 && n < lim) begin
      @(negedge hclk);
      n++;
    end
    if (n >= lim) begin
      fails++;
      $display("FAIL wait %0d timed out", k);
      conclude();
    end
  endtask
  // ==========================================================
  // AHB-Lite single word transfer; read data lands in rd
  task automatic hand();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      fails++;
      conclude();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    hand();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    hand();
    rd = hrdata;
  endtask
  // ==========================================================
  // low-power entry through the core model, then wake by irq
  task automatic enter(input logic [2:0] md, input logic [31:0] mk);
    bus(1'b1, PMWS_MODE_OFS, {29'h0, md});
    @(posedge hclk);
    sleep_go <= 1'b1;
    go_mask <= mk;
    @(posedge hclk);
    sleep_go <= 1'b0;
    repeat (4) @(negedge hclk);
  endtask
  task automatic measure(input int bi, input int lo, input int hi, input logic [2:0] md);
    @(posedge hclk);
    irq_lines <= 32'h1 << bi;
    wait_for(1, hi + 20);
    chk_rng("wake cycles", lo, hi, n);
    @(posedge hclk);
    irq_lines <= 32'h0;
    bus(1'b0, PMWS_STAT_OFS, 32'h0);
    chk("last mode", {29'h0, md}, {29'h0, rd[2:0]});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(66));
    {hresetn, hsel, hwrite, ext_reset_n, osc_stable, rtc_alarm} = '0;
    {haddr, htrans, hwdata, irq_lines, sleep_go, go_mask, slow} = '0;
    hsize = 3'b010;
    fails = 0;
    samples_checked = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // pin held past the flash count, then the oscillator still holds reset
    repeat (11000) @(posedge hclk);
    ext_reset_n <= 1'b1;
    repeat (100) @(negedge hclk);
    chk1("rst held", 1'b0, sys_reset_n);
    chk1("usb pll off", 1'b0, usb_pll_en);
    chk1("usb clk main", 1'b0, usb_clk_sel);
    chk("src rc", 32'h0, {30'h0, clk_src});
    chk("pcon rst", PMWS_PCON_RST, periph_clk_en);
    @(posedge hclk);
    osc_stable <= 1'b1;
    wait_for(0, 50);
    chk1("flash ok", 1'b1, pwr.flash_ok);
    repeat (4) begin
      m = $urandom;
      bus(1'b1, PMWS_PCON_OFS, m);
      bus(1'b0, PMWS_PCON_OFS, 32'h0);
      chk("pcon rd", m, rd);
      chk("pcon out", m, periph_clk_en);
    end
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, PMWS_CLK_OFS, 32'h10);
    repeat (3) @(negedge hclk);
    chk1("usb sel no osc", 1'b0, usb_clk_sel);
    bus(1'b1, PMWS_CLK_OFS, 32'h30);
    bus(1'b0, PMWS_STAT_OFS, 32'h0);
    chk1("osc ok", 1'b1, rd[7]);
    chk1("usb sel osc", 1'b1, usb_clk_sel);
    // sleep wakes on a raw line even outside the mask
    enter(PMWS_M_SLEEP, 32'h0);
    chk1("sleep core", 1'b0, pwr.core_clk_en);
    chk1("sleep periph", 1'b1, pwr.periph_clk_en);
    measure($urandom_range(31, 0), 1, 12, PMWS_M_SLEEP);
    // deep-sleep from the oscillator with pll and dividers set
    bus(1'b1, PMWS_CLK_OFS, 32'h00034E3D);
    b = $urandom_range(30, 0);
    m = $urandom | (32'h1 << b);
    m[b + 1] = 1'b0;
    enter(PMWS_M_DSLEEP, m);
    chk1("ds osc", 1'b0, pwr.osc_run);
    chk1("ds periph", 1'b0, pwr.periph_clk_en);
    chk1("ds irc out", 1'b0, pwr.irc_out_en);
    chk1("ds irc pwr", 1'b1, pwr.irc_pwr);
    chk1("ds flash", 1'b1, pwr.flash_pwr);
    chk1("ds pll", 1'b0, main_pll_en | main_pll_con);
    chk("ds div", 32'h0, {20'h0, cpu_div, usb_div});
    @(posedge hclk);
    irq_lines <= 32'h1 << (b + 1);
    repeat (60) @(negedge hclk);
    chk1("ds stays", 1'b0, pwr.core_clk_en);
    measure(b, 4096, 4110, PMWS_M_DSLEEP);
    bus(1'b0, PMWS_WMASK_OFS, 32'h0);
    chk("wake mask", m, rd);
    bus(1'b1, PMWS_CLK_OFS, 32'h20);
    slow <= 1'b1;
    enter(PMWS_M_DSLEEP, m);
    measure(b, 100, 114, PMWS_M_DSLEEP);
    enter(PMWS_M_PDOWN, m);
    chk1("pd irc pwr", 1'b0, pwr.irc_pwr);
    chk1("pd flash", 1'b0, pwr.flash_pwr);
    measure(b, 6100, 6114, PMWS_M_PDOWN);
    chk1("pd flash blk", 1'b0, pwr.flash_ok);
    wait_for(2, 10200);
    chk_rng("flash cycles", 9800, 10000, n);
    // deep power-down refused until armed, then left by the alarm and not by an irq
    bus(1'b1, PMWS_CLK_OFS, 32'h30);
    enter(PMWS_M_DPDOWN, m);
    chk1("dpd unarmed", 1'b1, pwr.core_pwr);
    bus(1'b1, PMWS_DPD_OFS, 32'h1);
    enter(PMWS_M_DPDOWN, m);
    chk1("dpd pwr", 1'b0, pwr.core_pwr);
    measure_none();
    bus(1'b0, PMWS_STAT_OFS, 32'h0);
    chk("dpd last", 32'h4, {29'h0, rd[2:0]});
    // pin reset in mid-run restarts the whole release sequence
    bus(1'b1, PMWS_CLK_OFS, 32'h30);
    @(posedge hclk);
    ext_reset_n <= 1'b0;
    repeat (8) @(negedge hclk);
    chk1("pin rst", 1'b0, sys_reset_n);
    @(posedge hclk);
    ext_reset_n <= 1'b1;
    wait_for(0, 10300);
    chk1("pin usb off", 1'b0, usb_pll_en);
    conclude();
  end
  task automatic measure_none();
    @(posedge hclk);
    irq_lines <= 32'h1 << b;
    repeat (200) @(negedge hclk);
    chk1("dpd irq", 1'b0, sys_reset_n);
    @(posedge hclk);
    irq_lines <= 32'h0;
    rtc_alarm <= 1'b1;
    repeat (4) @(posedge hclk);
    rtc_alarm <= 1'b0;
    wait_for(0, 10300);
    chk1("dpd usb off", 1'b0, usb_pll_en);
  endtask
endmodule

// ### hdl/pmws_pkg.sv
/*
  pmws_pkg: constants and types for the power-mode and wake-up sequencer.
  assumes a single 100 MHz bus clock and an AHB-Lite register port.
*/
package pmws_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] PMWS_MODE_OFS   = 8'h00; // low-power mode select
  localparam logic [7:0] PMWS_CLK_OFS    = 8'h04; // clock source / pll / dividers
  localparam logic [7:0] PMWS_STAT_OFS   = 8'h08; // sequencer status
  localparam logic [7:0] PMWS_PCON_OFS   = 8'h0C; // peripheral clock gates
  localparam logic [7:0] PMWS_WMASK_OFS  = 8'h10; // captured wake mask (read)
  localparam logic [7:0] PMWS_DPD_OFS    = 8'h14; // deep power-down request from rtc side
  // ==========================================================
  // field positions
  localparam int PMWS_CLK_SRC_LSB  = 0;  // 2-bit clock source
  localparam int PMWS_CLK_PLL_EN   = 2;  // main pll enable
  localparam int PMWS_CLK_PLL_CON  = 3;  // main pll connect
  localparam int PMWS_CLK_UPLL_EN  = 4;  // usb pll enable
  localparam int PMWS_CLK_OSC_EN   = 5;  // main oscillator enable
  localparam int PMWS_CLK_CDIV_LSB = 8;  // cpu divider, 8 bits
  localparam int PMWS_CLK_UDIV_LSB = 16; // usb divider, 4 bits
  localparam int PMWS_NUM_IRQ      = 32; // interrupt lines watched
  localparam int PMWS_NUM_PERIPH   = 32; // peripheral clock gates
  // ==========================================================
  // reset values
  localparam logic [31:0] PMWS_PCON_RST = 32'hFFFFFFFF; // peripherals clocked
  // ==========================================================
  // timing
  localparam int PMWS_CLK_MHZ       = 100;  // hclk rate
  localparam int PMWS_IRC_MHZ       = 4;    // rc oscillator rate
  localparam int PMWS_IRC_START_US  = 60;   // rc start-up after power-down
  localparam int PMWS_FLASH_US      = 100;  // flash start-up
  localparam int PMWS_IRC_WAKE_CYC  = 4;    // rc cycles before resuming
  localparam int PMWS_OSC_WAKE_CYC  = 4096; // oscillator cycles before resuming
  localparam int PMWS_RST_CYC       = 16;   // fixed count after reset release
  localparam int PMWS_IRC_START_CYC = PMWS_IRC_START_US * PMWS_CLK_MHZ;
  localparam int PMWS_FLASH_CYC     = PMWS_FLASH_US * PMWS_CLK_MHZ;
  localparam int PMWS_IRC_WAKE_HCLK = PMWS_IRC_WAKE_CYC * (PMWS_CLK_MHZ / PMWS_IRC_MHZ);
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    PMWS_SRC_IRC, PMWS_SRC_OSC, PMWS_SRC_RTC, PMWS_SRC_RSV
  } pmws_src_t;
  typedef enum logic [2:0] {
    PMWS_M_NONE, PMWS_M_SLEEP, PMWS_M_DSLEEP, PMWS_M_PDOWN, PMWS_M_DPDOWN
  } pmws_mode_t;
  typedef struct packed {
    logic core_clk_en;   // cpu_core_clock gate
    logic periph_clk_en; // peripheral clocks gate
    logic osc_run;       // main oscillator runs
    logic irc_out_en;    // internal_rc_osc output enabled
    logic irc_pwr;       // internal_rc_osc powered
    logic flash_pwr;     // flash powered
    logic flash_ok;      // flash access allowed
    logic core_pwr;      // main domain powered
  } pmws_pwr_t;
endpackage

// ### hdl/pmws_seq.sv
/*
  pmws_seq: power-mode and wake-up sequencer with AHB-Lite registers.
  assumes the core asserts sleep_req with the captured mask valid, and that
  reset and irq pins come from outside the hclk domain.
*/
// The address map and register access over AHB-Lite are this design's own decisions.
// Contract
// - usb pll disabled after any reset
// - usb clock from main pll while disabled
// - usb pll fed by oscillator, usb only
// - rc oscillator is clock at power-up, wake (code: wake keeps clk_src, except after power-down)
// - wake-up timer holds execution until oscillator safe
// - sleep gates core clock until irq/reset
// - peripherals run in sleep, irq wakes
// - deep-sleep stops oscillator, gates clocks, retains
// - deep-sleep gates rc output, rtc runs
// - deep-sleep kills pll, clears dividers
// - deep-sleep exits on reset/clockless irq only
// - deep-sleep wake waits 4 or 4096
// - power-down also unpowers rc and flash
// - flash counter blocks flash for 100 us
// - deep power-down entered from rtc only
// - deep power-down exit: pin or alarm
// - irq controller hands mask on entry
// - masked irq wakes cpu while stopped
// - per-peripheral clock gate
// - internal reset held until conditions met
`timescale 1ns/1ns
module pmws_seq
  import pmws_pkg::*;
(
  input  wire logic        hclk,          // 100 MHz bus clock
  input  wire logic        hresetn,       // async active-low reset
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_reset_n,   // reset pin, asynchronous
  input  wire logic        osc_stable,    // oscillator amplitude good, asynchronous
  input  wire logic        sleep_req,     // core sleep request, same clock
  input  wire logic [31:0] irq_mask,      // enabled, high-priority irqs from core
  input  wire logic [31:0] irq_lines,     // raw interrupt lines, asynchronous
  input  wire logic        rtc_alarm,     // rtc alarm match, asynchronous
  output logic             sys_reset_n,   // internal reset release
  output pmws_pwr_t        pwr,           // power and clock gates
  output logic             usb_pll_en,    // usb_dedicated_pll enable and power
  output logic             usb_clk_sel,   // 1: usb pll, 0: main pll 48 MHz
  output logic             main_pll_en,
  output logic             main_pll_con,
  output logic [1:0]       clk_src,
  output logic [7:0]       cpu_div,
  output logic [3:0]       usb_div,
  output logic [31:0]      periph_clk_en,
  output logic             wake_event     // one-cycle pulse on wake
);
  // ==========================================================
  // input synchronisers
  logic [1:0]  rst_s, osc_s, alm_s;        // two-stage level sync
  logic [31:0] irq_s0, irq_s1;             // irq sync stages
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_s  <= 2'h0;
      osc_s  <= 2'h0;
      alm_s  <= 2'h0;
      irq_s0 <= 32'h0;
      irq_s1 <= 32'h0;
    end else begin
      rst_s  <= {rst_s[0], ext_reset_n};
      osc_s  <= {osc_s[0], osc_stable};
      alm_s  <= {alm_s[0], rtc_alarm};
      irq_s0 <= irq_lines;
      irq_s1 <= irq_s0;
    end
  end
  wire pin_rst_n = rst_s[1];
  wire osc_ok    = osc_s[1];
  wire alarm     = alm_s[1];

  // ==========================================================
  // bus address phase capture
  logic       wr_pend, rd_pend;            // data phase pending
  logic [7:0] ph_addr;                     // latched offset
  wire        acc = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ph_addr <= 8'h0;
    end else begin
      wr_pend <= acc & hwrite;
      rd_pend <= acc & ~hwrite;
      if (acc) ph_addr <= haddr[7:0];
    end
  end
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction
  assign hreadyout = 1'b1;                 // zero wait states
  assign hresp     = 1'b0;                 // always okay

  // ==========================================================
  // sequencer state
  typedef enum logic [2:0] {
    S_RESET, S_RUN, S_SLEEP, S_STOP, S_IRC_UP, S_WAKE_WAIT, S_DPD
  } pmws_state_t;
  pmws_state_t state, next_state;
  pmws_mode_t  mode_sel, cur_mode, last_exit;
  logic [31:0] wake_mask;                  // captured mask from core
  logic [13:0] cnt;                        // wake/reset counter
  logic [13:0] flash_cnt;                  // flash start-up counter
  logic        src_was_osc;                // oscillator in use at entry
  logic        dpd_req;                    // rtc-side deep power-down request
  logic        osc_en;

  wire irq_hit = |(irq_s1 & wake_mask);
  wire wake_stop = (cur_mode == PMWS_M_DPDOWN) ? (alarm | ~pin_rst_n)
                                               : irq_hit;
  wire cnt_done  = (cnt == 14'h0);
  wire [13:0] wake_len = (cur_mode == PMWS_M_PDOWN) ? 14'(PMWS_IRC_WAKE_HCLK)
                        : src_was_osc ? 14'(PMWS_OSC_WAKE_CYC)
                        : 14'(PMWS_IRC_WAKE_HCLK);

  // next-state decode
  always_comb begin
    next_state = state;
    case (state)
      S_RESET:     if (pin_rst_n && osc_ok && cnt_done && flash_cnt == 14'h0)
                     next_state = S_RUN;
      S_RUN:       if (sleep_req && mode_sel != PMWS_M_NONE)
                     next_state = (mode_sel == PMWS_M_SLEEP) ? S_SLEEP
                                : (mode_sel == PMWS_M_DPDOWN) ? S_RUN : S_STOP;
      S_SLEEP:     if (|irq_s1) next_state = S_RUN;
      S_STOP:      if (wake_stop)
                     next_state = (cur_mode == PMWS_M_PDOWN) ? S_IRC_UP : S_WAKE_WAIT;
      S_IRC_UP:    if (cnt_done) next_state = S_WAKE_WAIT;
      S_WAKE_WAIT: if (cnt_done) next_state = S_RUN;
      S_DPD:       if (wake_stop) next_state = S_RESET;
      default:     next_state = S_RESET;
    endcase
    if (dpd_req && state == S_RUN && sleep_req && mode_sel == PMWS_M_DPDOWN)
      next_state = S_DPD;
    // the reset pin wins over every mode, sleep and stop included
    if (!pin_rst_n)
      next_state = S_RESET;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_RESET;
    end else begin
      state <= next_state;
    end
  end

  // counters and captured context
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt         <= 14'(PMWS_RST_CYC);
      flash_cnt   <= 14'(PMWS_FLASH_CYC);
      cur_mode    <= PMWS_M_NONE;
      last_exit   <= PMWS_M_NONE;
      wake_mask   <= 32'h0;
      src_was_osc <= 1'b0;
      wake_event  <= 1'b0;
    end else begin
      wake_event <= 1'b0;
      if (!cnt_done) cnt <= cnt - 14'h1;
      if (flash_cnt != 14'h0 && pwr.flash_pwr) flash_cnt <= flash_cnt - 14'h1;
      if (state == S_RUN && next_state != S_RUN) begin
        cur_mode    <= mode_sel;
        wake_mask   <= irq_mask;
        src_was_osc <= (clk_src == PMWS_SRC_OSC);
      end
      if (state == S_STOP && next_state != S_STOP) begin
        cnt <= (cur_mode == PMWS_M_PDOWN) ? 14'(PMWS_IRC_START_CYC) : wake_len;
        if (cur_mode == PMWS_M_PDOWN) flash_cnt <= 14'(PMWS_FLASH_CYC);
      end
      if (state == S_IRC_UP && cnt_done) cnt <= wake_len;
      // any way back into reset restarts the full release sequence
      if (state != S_RESET && next_state == S_RESET) begin
        cnt       <= 14'(PMWS_RST_CYC);
        flash_cnt <= 14'(PMWS_FLASH_CYC);
        if (state == S_DPD) last_exit <= PMWS_M_DPDOWN;
      end
      if (state != S_RUN && state != S_RESET && next_state == S_RUN) begin
        last_exit  <= cur_mode;
        wake_event <= 1'b1;
      end
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_sel      <= PMWS_M_NONE;
      clk_src       <= PMWS_SRC_IRC;
      main_pll_en   <= 1'b0;
      main_pll_con  <= 1'b0;
      usb_pll_en    <= 1'b0;
      osc_en        <= 1'b0;
      cpu_div       <= 8'h0;
      usb_div       <= 4'h0;
      periph_clk_en <= PMWS_PCON_RST;
      dpd_req       <= 1'b0;
    end else begin
      if (wr_pend && hit(ph_addr, PMWS_MODE_OFS)) mode_sel <= pmws_mode_t'(hwdata[2:0]);
      if (wr_pend && hit(ph_addr, PMWS_CLK_OFS)) begin
        clk_src      <= hwdata[PMWS_CLK_SRC_LSB +: 2];
        main_pll_en  <= hwdata[PMWS_CLK_PLL_EN];
        main_pll_con <= hwdata[PMWS_CLK_PLL_CON];
        usb_pll_en   <= hwdata[PMWS_CLK_UPLL_EN];
        osc_en       <= hwdata[PMWS_CLK_OSC_EN];
        cpu_div      <= hwdata[PMWS_CLK_CDIV_LSB +: 8];
        usb_div      <= hwdata[PMWS_CLK_UDIV_LSB +: 4];
      end
      if (wr_pend && hit(ph_addr, PMWS_PCON_OFS)) periph_clk_en <= hwdata;
      if (wr_pend && hit(ph_addr, PMWS_DPD_OFS)) dpd_req <= hwdata[0];
      if (state == S_RUN && next_state == S_STOP) begin
        main_pll_en  <= 1'b0;
        main_pll_con <= 1'b0;
        cpu_div      <= 8'h0;
        usb_div      <= 4'h0;
        if (mode_sel == PMWS_M_PDOWN) clk_src <= PMWS_SRC_IRC;
      end
      if (next_state == S_DPD) dpd_req <= 1'b0;
      // power loss or pin reset: every register written over the bus returns to its reset value
      if (state != S_RESET && next_state == S_RESET) begin
        mode_sel      <= PMWS_M_NONE;
        clk_src       <= PMWS_SRC_IRC;
        main_pll_en   <= 1'b0;
        main_pll_con  <= 1'b0;
        usb_pll_en    <= 1'b0;
        osc_en        <= 1'b0;
        cpu_div       <= 8'h0;
        usb_div       <= 4'h0;
        periph_clk_en <= PMWS_PCON_RST;
        dpd_req       <= 1'b0;
      end
    end
  end

  // usb clock source: dedicated pll only when enabled and oscillator enabled
  assign usb_clk_sel = usb_pll_en & osc_en;

  // ==========================================================
  // power and clock gate outputs
  wire stopped = (state == S_STOP) || (state == S_DPD);
  wire pd_like = (cur_mode == PMWS_M_PDOWN) && (state == S_STOP || state == S_IRC_UP);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr         <= '0;
      sys_reset_n <= 1'b0;
      hrdata      <= 32'h0;
    end else begin
      sys_reset_n       <= (state != S_RESET) && (state != S_DPD);
      pwr.core_clk_en   <= (state == S_RUN);
      pwr.periph_clk_en <= ~stopped && state != S_RESET;
      pwr.osc_run       <= osc_en & ~stopped;
      pwr.irc_out_en    <= ~stopped && state != S_IRC_UP;
      pwr.irc_pwr       <= ~pd_like && state != S_DPD;
      pwr.flash_pwr     <= ~pd_like && state != S_DPD;
      pwr.flash_ok      <= (flash_cnt == 14'h0) && ~pd_like;
      pwr.core_pwr      <= (state != S_DPD);
      hrdata <= 32'h0;
      if (rd_pend || acc) begin
        if (hit(haddr[7:0], PMWS_MODE_OFS)) hrdata <= {29'h0, mode_sel};
        else if (hit(haddr[7:0], PMWS_CLK_OFS))
          hrdata <= {12'h0, usb_div, cpu_div, 2'h0, osc_en, usb_pll_en,
                     main_pll_con, main_pll_en, clk_src};
        else if (hit(haddr[7:0], PMWS_STAT_OFS))
          hrdata <= {24'h0, osc_ok, pwr.flash_ok, 3'h0, last_exit};
        else if (hit(haddr[7:0], PMWS_PCON_OFS)) hrdata <= periph_clk_en;
        else if (hit(haddr[7:0], PMWS_WMASK_OFS)) hrdata <= wake_mask;
        else if (hit(haddr[7:0], PMWS_DPD_OFS)) hrdata <= {31'h0, dpd_req};
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_enter_stop;
    state == S_RUN ##1 state == S_STOP;
  endsequence
  usb_pll_off_a: assert property (@(posedge hclk) $rose(hresetn) |-> !usb_pll_en)
    else $error("usb pll on after reset");
  usb_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !usb_pll_en |-> !usb_clk_sel) else $error("usb clock from disabled pll");
  div_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_enter_stop |-> cpu_div == 8'h0 && usb_div == 4'h0 && !main_pll_en)
    else $error("dividers not cleared on deep-sleep");
  core_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == S_SLEEP |=> !pwr.core_clk_en) else $error("core clock runs in sleep");
  mask_cap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_enter_stop |-> wake_mask == $past(irq_mask, 1)) else $error("mask not captured");
  stop_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == S_STOP && !wake_stop && pin_rst_n |=> state == S_STOP)
    else $error("stray wake");
  ds_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == S_STOP && cur_mode == PMWS_M_DSLEEP && !src_was_osc && irq_hit && pin_rst_n
    |=> ##[100:102] state == S_RUN) else $error("deep-sleep wake length wrong");
  pd_flash_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pd_like |=> !pwr.flash_pwr && !pwr.irc_pwr) else $error("power-down supplies on");
  rst_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !pin_rst_n && state == S_RESET |=> !sys_reset_n) else $error("reset released early");
  dpd_regs_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == S_DPD && next_state == S_RESET |=> !usb_pll_en && mode_sel == PMWS_M_NONE)
    else $error("registers kept over deep power-down");
endmodule
